/* File: hdl/didt_decoder.sv */
// Summary of operation
// - Each single word is 24 bits with an 8-bit opcode choosing the type.
// - Three opcodes span two words; all others take one word.
// - A two-word instruction is 48 bits; second word has top byte zero.
// - A lone second word executes as a no-operation.
// - One cycle normally; two when a test is true, extra cycle is idle.
// - Jumps, indirect calls, table access and returns take two or three.
// - A taken skip costs two cycles, three over a two-word instruction.
// - Two-word instructions finish in two cycles.
// - Register ops: plain base source, moded second source and result.
// - File ops: file address, result to file or default register.
// - Bit ops: register or file target, bit from literal or register.
// - Literal ops: base plus literal; result field only if not the base.
// - Multiply-sum ops decode accumulator, pair, prefetch and write-back.
// - Other accumulator ops: accumulator, moded operand, shift amount.
// - Write-back target is register 13 direct or post-increment by 2.
// - Bit position field is 4 bits, positions 0 to 15.
// - Word mode by default; byte, double-word or shadow on request.
// - Keeps general flags and four accumulator wrap and clamp flags.
// - Squares pair 4..7 with itself; products use six distinct pairs.
// - X prefetch on 8/9 or 9+12; Y prefetch on 10/11 or 11+12.
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module didt_decoder
   import didt_pkg::*;
(
   input wire logic I_CLK, // Core instruction clock
   input wire logic I_NRST, // Async reset, active low
   input wire logic I_INSTR_VALID, // Word present
   input wire logic [IW-1:0] I_INSTR, // Program word
   input wire logic I_COND, // Condition true
   input wire logic I_FLAG_WE, // Execute flag write
   input wire didt_flags_t I_FLAGS, // Execute flags
   input wire logic [1:0] I_ADDR, // Register address
   input wire logic [15:0] I_WDATA, // Write data
   input wire logic I_WR, // Write strobe
   input wire logic I_RD, // Read strobe
   output logic O_READY, // Word accepted
   output logic O_DEC_VALID, // Decode pulse
   output didt_dec_t O_DEC, // Decoded fields
   output logic O_RETIRE, // Last cycle pulse
   output logic [1:0] O_CYCLES, // Cycles taken
   output logic O_NOP_SLOT, // Idle cycle
   output didt_flags_t O_FLAGS, // Status flags
   output logic [15:0] O_RDATA // Read data
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef enum logic [2:0] {PH_FIRST, PH_SECOND, PH_SKIP, PH_SKIP2,
      PH_PAD} didt_ph_t;
   typedef struct packed {
      didt_ph_t ph;
      logic [1:0] pad;
      logic [1:0] tot;
      logic ready;
      logic dvalid;
      logic retire;
      logic [1:0] cycles;
      logic nop;
      didt_dec_t dec;
      didt_flags_t flags;
      logic en;
      logic err_dw;
      logic err_pair;
      logic [15:0] rdata;
   } didt_st_t;

   didt_st_t s_r;
   didt_st_t s_nxt;
   didt_dec_t d;
   logic take;
   logic [1:0] tot;

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   function automatic didt_pf_t pf_dec(input logic [3:0] c,
                                       input logic [3:0] lo);
      didt_pf_t p;
      logic [2:0] k;
      p = '0;
      k = (c < 4'h7) ? c[2:0] : 3'(c - 4'h7);
      if (c == PF_NONE) begin
         p.none = 1'b1;
      end else if (c == PF_IDX) begin
         p.areg = 4'(lo + 4'h1);
         p.idx = 1'b1;
      end else begin
         p.areg = (c < 4'h7) ? lo : 4'(lo + 4'h1);
         p.step = 4'sh6 - $signed({k, 1'b0});
      end
      return p;
   endfunction

   function automatic didt_dec_t decode(input logic [IW-1:0] w);
      didt_dec_t r;
      logic [7:0] op;
      logic [3:0] mm;
      r = '0;
      op = w[OPC_LSB +: 8];
      mm = w[F_MM +: 4];
      r.opcode = op;
      r.cls = CL_CTRL;
      r.mode = MD_WORD;
      r.dw = (op == OP_DGOTO) || (op == OP_DCALL) || (op == OP_DMOV);
      if (op == OP_NOP) begin
         r.cls = CL_NOP;
      end else if (op[7:5] == PFX_DEFAULT_WORKING_REGISTER) begin
         r.cls = CL_DEFAULT_WORKING_REGISTER;
         r.mode = didt_mode_t'(op[4:3]);
         r.base_source_register = w[F_BASE +: RW];
         r.second_source_register = w[F_SRC +: RW];
         r.src_amode = w[F_SAM +: 3];
         r.result_register = w[F_DST +: RW];
         r.dst_amode = op[2:0];
      end else if (op[7:5] == PFX_FILE) begin
         r.cls = CL_FILE;
         r.mode = didt_mode_t'(op[4:3]);
         r.to_default_working_register = op[2];
         r.file_addr = w[FA_W-1:0];
         r.on_file = 1'b1;
      end else if (op[7:4] == NIB_BITW) begin
         r.cls = CL_BIT;
         r.bit_from_reg = op[3];
         r.second_source_register = w[F_SRC +: RW];
         r.src_amode = w[F_LIT - 2 +: 3];
         if (op[3]) begin
            r.base_source_register = w[F_BASE +: RW];
         end else begin
            r.bit_position_field = w[F_BASE +: RW];
         end
      end else if (op[7:4] == NIB_BITF) begin
         r.cls = CL_BIT;
         r.on_file = 1'b1;
         r.bit_position_field = op[3:0];
         r.file_addr = w[FA_W-1:0];
      end else if (op[7:5] == PFX_LIT) begin
         r.cls = CL_LIT;
         r.mode = didt_mode_t'(op[4:3]);
         r.base_source_register = w[F_BASE +: RW];
         r.literal = {1'b0, w[F_LIT +: 5]};
         if (op[2]) begin
            r.result_register = w[F_LDST +: RW];
            r.dst_amode = w[2:0];
         end else begin
            r.result_register = w[F_BASE +: RW];
         end
      end else if (op[7:4] == NIB_MAC) begin
         r.cls = CL_MAC;
         r.acc_b = w[F_ACC];
         if (mm < 4'h3) begin
            r.mul_a = MUL_LO;
            r.mul_b = 4'(MUL_LO + mm + 4'h1);
            r.pair_ok = 1'b1;
         end else if (mm < 4'h5) begin
            r.mul_a = 4'(MUL_LO + 4'h1);
            r.mul_b = 4'(MUL_LO + mm - 4'h1);
            r.pair_ok = 1'b1;
         end else if (mm == 4'h5) begin
            r.mul_a = 4'(MUL_LO + 4'h2);
            r.mul_b = 4'(MUL_LO + 4'h3);
            r.pair_ok = 1'b1;
         end else if (mm[3:2] == 2'b10) begin
            r.mul_a = 4'(MUL_LO + {2'b00, mm[1:0]});
            r.mul_b = 4'(MUL_LO + {2'b00, mm[1:0]});
            r.pair_ok = 1'b1;
         end
         r.x_pf = pf_dec(w[F_X +: 4], X_LO);
         r.y_pf = pf_dec(w[F_Y +: 4], Y_LO);
         r.x_dest = 4'(MUL_LO + {2'b00, w[F_XD +: 2]});
         r.y_dest = 4'(MUL_LO + {2'b00, w[F_YD +: 2]});
         r.product_writeback_target = w[F_AWB +: 2];
         r.result_register = AWB_REG;
      end else if (op[7:4] == NIB_ACC) begin
         r.cls = CL_ACC;
         r.acc_b = op[3];
         r.shift_from_reg = op[2];
         r.second_source_register = w[F_BASE +: RW];
         r.src_amode = w[F_AAM +: 3];
         if (op[2]) begin
            r.base_source_register = w[RW-1:0];
         end else begin
            r.literal = w[5:0];
         end
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // Cycle budget of a single-word instruction
   // ------------------------------------------------------------
   always_comb begin
      d = decode(I_INSTR);
      take = I_INSTR_VALID && s_r.ready;
      case (d.opcode)
         OP_RJMP, OP_CJMP, OP_ICALL, OP_IGOTO: tot = CYC_JUMP;
         OP_TBLRD, OP_TBLWR: tot = CYC_TABLE;
         OP_RET, OP_IEXIT: tot = CYC_RET;
         OP_CBR: tot = I_COND ? CYC_TWO : CYC_ONE;
         default: tot = CYC_ONE;
      endcase
   end

   // ------------------------------------------------------------
   // Sequencer and registers
   // ------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.dvalid = 1'b0;
      s_nxt.retire = 1'b0;
      s_nxt.nop = 1'b0;
      s_nxt.rdata = '0;
      case (s_r.ph)
         PH_FIRST: begin
            if (take) begin
               s_nxt.dec = d;
               s_nxt.dvalid = 1'b1;
               s_nxt.err_pair = s_r.err_pair ||
                  (d.cls == CL_MAC && !d.pair_ok);
               if (d.dw) begin
                  s_nxt.ph = PH_SECOND;
               end else if (d.opcode == OP_SKIP && I_COND) begin
                  s_nxt.ph = PH_SKIP;
               end else if (tot != CYC_ONE) begin
                  s_nxt.ph = PH_PAD;
                  s_nxt.tot = tot;
                  s_nxt.pad = 2'(tot - CYC_ONE);
               end else begin
                  // zero opcode is a plain idle
                  s_nxt.retire = 1'b1;
                  s_nxt.cycles = CYC_ONE;
               end
            end
         end
         PH_SECOND: begin
            if (take) begin
               // second word ends it in two
               s_nxt.nop = 1'b1;
               s_nxt.retire = 1'b1;
               s_nxt.cycles = CYC_TWO;
               s_nxt.dec.ext_word = I_INSTR[15:0];
               s_nxt.ph = PH_FIRST;
               if (I_INSTR[OPC_LSB +: 8] != 8'h00) begin
                  s_nxt.err_dw = 1'b1;
               end
            end
         end
         PH_SKIP: begin
            if (take) begin
               s_nxt.nop = 1'b1;
               if (d.dw) begin
                  s_nxt.ph = PH_SKIP2;
               end else begin
                  s_nxt.retire = 1'b1;
                  s_nxt.cycles = CYC_TWO;
                  s_nxt.ph = PH_FIRST;
               end
            end
         end
         PH_SKIP2: begin
            if (take) begin
               s_nxt.nop = 1'b1;
               s_nxt.retire = 1'b1;
               s_nxt.cycles = CYC_THREE;
               s_nxt.ph = PH_FIRST;
            end
         end
         PH_PAD: begin
            s_nxt.nop = 1'b1;
            s_nxt.pad = 2'(s_r.pad - 2'h1);
            if (s_r.pad == 2'h1) begin
               s_nxt.retire = 1'b1;
               s_nxt.cycles = s_r.tot;
               s_nxt.ph = PH_FIRST;
            end
         end
         default: s_nxt.ph = PH_FIRST;
      endcase
      // A clear keeps a set of the same cycle, so the set wins
      if (I_WR) begin
         case (I_ADDR)
            A_FLAGS: begin
               s_nxt.flags = {I_WDATA[11:8], I_WDATA[4:0]};
            end
            A_CTRL: s_nxt.en = I_WDATA[0];
            A_STAT: begin
               if (I_WDATA[1]) begin
                  s_nxt.err_dw = (s_r.ph == PH_SECOND) && take &&
                     (I_INSTR[OPC_LSB +: 8] != 8'h00);
               end
               if (I_WDATA[2]) begin
                  s_nxt.err_pair = (s_r.ph == PH_FIRST) && take &&
                     d.cls == CL_MAC && !d.pair_ok;
               end
            end
            default: s_nxt.en = s_r.en;
         endcase
      end
      if (I_FLAG_WE) begin
         s_nxt.flags = I_FLAGS;
      end
      if (I_RD) begin
         case (I_ADDR)
            A_FLAGS: begin
               s_nxt.rdata = {4'h0, s_r.flags[8:5], 3'h0,
                  s_r.flags[4:0]};
            end
            A_CTRL: s_nxt.rdata = {15'h0000, s_r.en};
            A_STAT: begin
               s_nxt.rdata = {13'h0000, s_r.err_pair, s_r.err_dw,
                  s_r.ph != PH_FIRST};
            end
            default: s_nxt.rdata = '0;
         endcase
      end
      // Readiness is registered, so padding stalls the fetch
      s_nxt.ready = s_nxt.en && s_nxt.ph != PH_PAD;
   end

   always_ff @(posedge I_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         s_r <= '0;
         s_r.en <= CTRL_EN_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign O_READY = s_r.ready;
   assign O_DEC_VALID = s_r.dvalid;
   assign O_DEC = s_r.dec;
   assign O_RETIRE = s_r.retire;
   assign O_CYCLES = s_r.cycles;
   assign O_NOP_SLOT = s_r.nop;
   assign O_FLAGS = s_r.flags;
   assign O_RDATA = s_r.rdata;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   logic first_take;
   assign first_take = take && s_r.ph == PH_FIRST;

   property p_dw_two;
      @(posedge I_CLK) disable iff (!I_NRST)
      first_take && d.dw |=> s_r.ph == PH_SECOND;
   endproperty
   a_dw_two: assert property (p_dw_two)
      else $error("double word not awaited");

   property p_dw_cyc;
      @(posedge I_CLK) disable iff (!I_NRST)
      s_r.ph == PH_SECOND && take |=> O_RETIRE && O_CYCLES == 2'h2;
   endproperty
   a_dw_cyc: assert property (p_dw_cyc)
      else $error("double word not two cycles");

   property p_second_chk;
      @(posedge I_CLK) disable iff (!I_NRST)
      s_r.ph == PH_SECOND && take && I_INSTR[23:16] != 8'h00
         |=> s_r.err_dw;
   endproperty
   a_second_chk: assert property (p_second_chk)
      else $error("bad second word not flagged");

   property p_lone_nop;
      @(posedge I_CLK) disable iff (!I_NRST)
      first_take && I_INSTR[23:16] == 8'h00
         |=> O_DEC.cls == CL_NOP && O_RETIRE && O_CYCLES == 2'h1;
   endproperty
   a_lone_nop: assert property (p_lone_nop)
      else $error("zero word not idle");

   property p_cbr;
      @(posedge I_CLK) disable iff (!I_NRST)
      first_take && d.opcode == OP_CBR && I_COND
         |=> !O_RETIRE ##1 O_RETIRE && O_NOP_SLOT && O_CYCLES == 2'h2;
   endproperty
   a_cbr: assert property (p_cbr)
      else $error("taken branch not two cycles");

   property p_ret;
      @(posedge I_CLK) disable iff (!I_NRST)
      first_take && d.opcode == OP_RET
         |=> !O_READY [*2] ##1 O_RETIRE && O_CYCLES == 2'h3;
   endproperty
   a_ret: assert property (p_ret)
      else $error("return not three cycles");

   property p_skip1;
      @(posedge I_CLK) disable iff (!I_NRST)
      s_r.ph == PH_SKIP && take && !d.dw
         |=> O_RETIRE && O_NOP_SLOT && O_CYCLES == 2'h2;
   endproperty
   a_skip1: assert property (p_skip1)
      else $error("short skip not two cycles");

   property p_skip2;
      @(posedge I_CLK) disable iff (!I_NRST)
      s_r.ph == PH_SKIP2 && take |=> O_RETIRE && O_CYCLES == 2'h3;
   endproperty
   a_skip2: assert property (p_skip2)
      else $error("long skip not three cycles");

   property p_pair;
      @(posedge I_CLK) disable iff (!I_NRST)
      first_take && d.cls == CL_MAC && I_INSTR[18:15] < 4'h6
         |=> O_DEC.mul_a < O_DEC.mul_b && O_DEC.mul_a >= 4'h4 &&
            O_DEC.mul_b <= 4'h7;
   endproperty
   a_pair: assert property (p_pair)
      else $error("bad multiply pair");

   property p_lit_dst;
      @(posedge I_CLK) disable iff (!I_NRST)
      first_take && d.cls == CL_LIT && !I_INSTR[18]
         |=> O_DEC.result_register == $past(I_INSTR[15:12]);
   endproperty
   a_lit_dst: assert property (p_lit_dst)
      else $error("literal result not base");

   c_dw: cover property (@(posedge I_CLK) disable iff (!I_NRST)
      s_r.ph == PH_SECOND && take);
   c_skip2: cover property (@(posedge I_CLK) disable iff (!I_NRST)
      s_r.ph == PH_SKIP2 && take);
   c_ret: cover property (@(posedge I_CLK) disable iff (!I_NRST)
      first_take && d.opcode == OP_RET);
endmodule // didt_decoder
`default_nettype wire

/* File: shared/didt_pkg.sv */
`default_nettype none
package didt_pkg;
   // ------------------------------------------------------------
   // Word layout
   // ------------------------------------------------------------
   localparam int unsigned IW = 24;
   localparam int unsigned OPC_LSB = 16;
   localparam int unsigned RW = 4;
   localparam int unsigned F_BASE = 12;
   localparam int unsigned F_SRC = 8;
   localparam int unsigned F_DST = 4;
   localparam int unsigned F_SAM = 1;
   localparam int unsigned F_LDST = 3;
   localparam int unsigned F_LIT = 7;
   localparam int unsigned F_AAM = 9;
   localparam int unsigned F_ACC = 19;
   localparam int unsigned F_MM = 15;
   localparam int unsigned F_X = 11;
   localparam int unsigned F_Y = 7;
   localparam int unsigned F_XD = 5;
   localparam int unsigned F_YD = 3;
   localparam int unsigned F_AWB = 1;
   localparam int unsigned FA_W = 13;
   // ------------------------------------------------------------
   // Opcodes and class prefixes
   // ------------------------------------------------------------
   localparam logic [7:0] OP_NOP = 8'h00;
   localparam logic [7:0] OP_RJMP = 8'h01;
   localparam logic [7:0] OP_CJMP = 8'h02;
   localparam logic [7:0] OP_ICALL = 8'h03;
   localparam logic [7:0] OP_IGOTO = 8'h04;
   localparam logic [7:0] OP_TBLRD = 8'h05;
   localparam logic [7:0] OP_TBLWR = 8'h06;
   localparam logic [7:0] OP_RET = 8'h07;
   localparam logic [7:0] OP_IEXIT = 8'h08;
   localparam logic [7:0] OP_CBR = 8'h09;
   localparam logic [7:0] OP_SKIP = 8'h0a;
   localparam logic [7:0] OP_DGOTO = 8'h0b;
   localparam logic [7:0] OP_DCALL = 8'h0c;
   localparam logic [7:0] OP_DMOV = 8'h0d;
   localparam logic [2:0] PFX_DEFAULT_WORKING_REGISTER = 3'h2;
   localparam logic [2:0] PFX_FILE = 3'h3;
   localparam logic [2:0] PFX_LIT = 3'h5;
   localparam logic [3:0] NIB_BITW = 4'h8;
   localparam logic [3:0] NIB_BITF = 4'h9;
   localparam logic [3:0] NIB_MAC = 4'hc;
   localparam logic [3:0] NIB_ACC = 4'hd;
   // ------------------------------------------------------------
   // Multiply operands and prefetch
   // ------------------------------------------------------------
   localparam logic [3:0] MUL_LO = 4'h4;
   localparam logic [3:0] X_LO = 4'h8;
   localparam logic [3:0] Y_LO = 4'ha;
   localparam logic [3:0] PF_OFS_REG = 4'hc;
   localparam logic [3:0] PF_IDX = 4'he;
   localparam logic [3:0] PF_NONE = 4'hf;
   localparam logic [3:0] AWB_REG = 4'hd;
   localparam logic [1:0] AWB_DIRECT = 2'h1;
   localparam logic [1:0] AWB_POSTINC = 2'h2;
   // ------------------------------------------------------------
   // Cycle counts, register map, reset values
   // ------------------------------------------------------------
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;
   localparam logic [1:0] CYC_THREE = 2'h3;
   localparam logic [1:0] CYC_JUMP = 2'h2;
   localparam logic [1:0] CYC_TABLE = 2'h2;
   localparam logic [1:0] CYC_RET = 2'h3;
   localparam logic [1:0] A_FLAGS = 2'h0;
   localparam logic [1:0] A_CTRL = 2'h1;
   localparam logic [1:0] A_STAT = 2'h2;
   localparam logic CTRL_EN_RST = 1'b1;
   typedef enum logic [1:0] {MD_WORD, MD_BYTE, MD_DWORD, MD_SHADOW}
      didt_mode_t;
   typedef enum logic [2:0] {CL_NOP, CL_CTRL, CL_DEFAULT_WORKING_REGISTER, CL_FILE, CL_BIT,
      CL_LIT, CL_MAC, CL_ACC} didt_cls_t;
   typedef struct packed {
      logic second_sum_clamp_flag;
      logic first_sum_clamp_flag;
      logic second_sum_wrap_flag;
      logic first_sum_wrap_flag;
      logic zero;
      logic signed_wrap_flag;
      logic negative;
      logic half_carry_flag;
      logic carry;
   } didt_flags_t;
   typedef struct packed {
      logic [3:0] areg;
      logic signed [3:0] step;
      logic idx;
      logic none;
   } didt_pf_t;
   typedef struct packed {
      logic [7:0] opcode;
      didt_cls_t cls;
      didt_mode_t mode;
      logic dw;
      logic [3:0] base_source_register;
      logic [3:0] second_source_register;
      logic [2:0] src_amode;
      logic [3:0] result_register;
      logic [2:0] dst_amode;
      logic [12:0] file_addr;
      logic to_default_working_register;
      logic on_file;
      logic [3:0] bit_position_field;
      logic bit_from_reg;
      logic [5:0] literal;
      logic shift_from_reg;
      logic acc_b;
      logic [3:0] mul_a;
      logic [3:0] mul_b;
      logic pair_ok;
      didt_pf_t x_pf;
      didt_pf_t y_pf;
      logic [3:0] x_dest;
      logic [3:0] y_dest;
      logic [1:0] product_writeback_target;
      logic [15:0] ext_word;
   } didt_dec_t;
endpackage
`default_nettype wire

/* File: test/didt_progmem.sv */
`timescale 1ns/1ns
`default_nettype none
module didt_progmem
   import didt_pkg::*;
(
   input wire logic i_clk, // Instruction clock
   input wire logic i_nrst, // Reset, active low
   input wire logic i_go, // Fetch enable
   input wire logic i_ready, // Word taken
   output logic o_valid, // Word present
   output logic [IW-1:0] o_word, // Program word
   output logic o_cond // Condition for word
);
   logic [IW-1:0] mem [0:63];
   logic cnd [0:63];
   logic [IW-1:0] last_r;
   int n = 0;
   int p = 0;
   // Idle bus shows the inverted last word, so stale data never passes
   assign o_valid = i_go && (p < n);
   assign o_word = o_valid ? mem[p] : ~last_r;
   assign o_cond = o_valid ? cnd[p] : ~last_r[0];
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         p <= 0;
         last_r <= '0;
      end else if (o_valid && i_ready) begin
         p <= p + 1;
         last_r <= mem[p];
      end
   end
endmodule // didt_progmem
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import didt_pkg::*;
;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic fwe = 1'b0;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic go = 1'b0;
   logic [1:0] addr = 2'h0;
   logic [15:0] wdata = 16'h0000;
   didt_flags_t fl = '0;
   logic valid, cond, ready, retire, dval, nop;
   logic [IW-1:0] word;
   didt_dec_t dec;
   logic [1:0] cyc;
   didt_flags_t oflags, flags;
   logic [15:0] rdata, w;
   logic [15:0] seed = 16'h0042;
   logic [29:0] e;
   logic [29:0] eq [$];
   logic [7:0] cls_op [8] = '{8'ha5, 8'ha1, 8'h64, 8'h88, 8'h93, 8'hc0,
      8'hc3, 8'hd4};
   int n_nop = 0;
   int n_dv = 0;
   int n_ins = 0;
   int n_fail = 0;
   int comparisons = 0;
   didt_decoder u_didt_decoder (.I_CLK(clk), .I_NRST(nrst),
      .I_INSTR_VALID(valid), .I_INSTR(word), .I_COND(cond),
      .I_FLAG_WE(fwe), .I_FLAGS(fl), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr_s), .I_RD(rd_s), .O_READY(ready), .O_DEC_VALID(dval),
      .O_DEC(dec), .O_RETIRE(retire), .O_CYCLES(cyc), .O_NOP_SLOT(nop),
      .O_FLAGS(oflags), .O_RDATA(rdata));
   didt_progmem u_didt_progmem (.i_clk(clk), .i_nrst(nrst), .i_go(go),
      .i_ready(ready), .o_valid(valid), .o_word(word), .o_cond(cond));
   initial forever #4 clk = ~clk;
   function automatic logic [15:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed;
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      comparisons++;
      if (s !== x) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [15:0] x);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 chk(rdata, x);
   endtask
   task automatic put(input logic [23:0] v, input logic c);
      u_didt_progmem.mem[u_didt_progmem.n] = v;
      u_didt_progmem.cnd[u_didt_progmem.n] = c;
      u_didt_progmem.n++;
   endtask
   function automatic logic isdw(input logic [7:0] op);
      return op inside {OP_DGOTO, OP_DCALL, OP_DMOV};
   endfunction
   // Operand class from the opcode map
   function automatic logic [2:0] ecls(input logic [7:0] op);
      case (op[7:4])
         4'h0: return (op == OP_NOP) ? CL_NOP : CL_CTRL;
         4'h4, 4'h5: return CL_DEFAULT_WORKING_REGISTER;
         4'h6, 4'h7: return CL_FILE;
         4'h8, 4'h9: return CL_BIT;
         4'ha, 4'hb: return CL_LIT;
         4'hc: return CL_MAC;
         4'hd: return CL_ACC;
         default: return CL_CTRL;
      endcase
   endfunction
   // ------------------------------------------------------------
   // Reference model of cycle counts
   // ------------------------------------------------------------
   task automatic model();
      int i;
      logic [7:0] op;
      logic [10:0] h;
      logic [1:0] k;
      i = 0;
      while (i < u_didt_progmem.n) begin
         op = u_didt_progmem.mem[i][23:16];
         h = {ecls(op), op};
         if (isdw(op)) begin
            eq.push_back({h, 2'h2, 1'b1, u_didt_progmem.mem[i+1][15:0]});
            i += 2;
         end else if (op == OP_SKIP && u_didt_progmem.cnd[i]) begin
            op = u_didt_progmem.mem[i+1][23:16];
            eq.push_back({h, isdw(op) ? 2'h3 : 2'h2, 17'h0});
            i += isdw(op) ? 3 : 2;
         end else begin
            if (op == OP_RET || op == OP_IEXIT) k = 2'h3;
            else if (op inside {[8'h01:8'h06]}) k = 2'h2;
            else if (op == OP_CBR && u_didt_progmem.cnd[i]) k = 2'h2;
            else k = 2'h1;
            eq.push_back({h, k, 17'h0});
            i += 1;
         end
      end
   endtask
   // Idle slots of one instruction are counted up to its retire
   always @(posedge clk) begin
      if (nop === 1'b1) n_nop++;
      if (dval === 1'b1) n_dv++;
      if (retire === 1'b1) begin
         if (eq.size() == 0) chk(1, 0);
         else begin
            e = eq.pop_front();
            chk(cyc, e[18:17]);
            chk(n_nop, e[18:17] - 2'h1);
            chk(dec.opcode, e[26:19]);
            chk(dec.cls, e[29:27]);
            if (e[16]) chk(dec.ext_word, e[15:0]);
         end
         n_nop = 0;
      end
   end
   task automatic summarize();
      if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #100000;
      n_fail++;
      summarize();
   end
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      rd(A_CTRL, 16'h0001);
      rd(2'h3, 16'h0000);
      w = rnd();
      flags = w[8:0];
      @(posedge clk);
      fl <= flags;
      fwe <= 1'b1;
      @(posedge clk);
      fwe <= 1'b0;
      rd(A_FLAGS, {4'h0, flags[8:5], 3'h0, flags[4:0]});
      chk(oflags, flags);
      wr(A_FLAGS, 16'h0f1f);
      rd(A_FLAGS, 16'h0f1f);
      put({8'h00, rnd()}, 1'b0);
      for (int r = 0; r < 2; r++) begin
         for (int op = 0; op < 14; op++) begin
            w = rnd();
            put({op[7:0], w}, w[3]);
            if (op > 10) put({8'h00, rnd()}, 1'b0);
         end
      end
      put({OP_SKIP, rnd()}, 1'b1);
      put({OP_DMOV, rnd()}, 1'b0);
      put({8'h00, rnd()}, 1'b0);
      put({OP_SKIP, rnd()}, 1'b1);
      put({8'h4c, rnd()}, 1'b0);
      foreach (cls_op[j]) put({cls_op[j], rnd()}, 1'b0);
      put({OP_DGOTO, rnd()}, 1'b0);
      put({8'h5a, rnd()}, 1'b0);
      model();
      n_ins = eq.size();
      wr(A_CTRL, 16'h0000);
      repeat (2) @(posedge clk);
      go <= 1'b1;
      repeat (4) @(posedge clk);
      chk(ready, 1'b0);
      chk(u_didt_progmem.p, 0);
      wr(A_CTRL, 16'h0001);
      for (int t = 0; t < 2000; t++) begin
         if (u_didt_progmem.p >= u_didt_progmem.n) break;
         @(posedge clk);
      end
      repeat (4) @(posedge clk);
      chk(eq.size(), 0);
      chk(n_dv, n_ins);
      rd(A_STAT, 16'h0006);
      wr(A_STAT, 16'h0006);
      rd(A_STAT, 16'h0000);
      summarize();
   end
endmodule // tb_top
`default_nettype wire
